// File: design/fpll_ctrl.sv
// Behaviour
// - pre-divider is free-running 5-bit counter
// - fractional denominator programmable 1 to 4194303
// - ratio equals integer plus top over bottom
// - phase detector compares both divider outputs
// - 4-bit pump select enables weighted slices
// - power-down high means normal operation
// - power-down low or soft-reset 0 resets
// - leaving reset starts calibration sequence
// - pin exit reloads pin-mode defaults
// - soft reset keeps configuration registers
// - soft-reset bit rests at one
// - calibrate after timer expires and supplies valid
// - auto-mute channels muted during calibration
// - successful calibration proceeds to lock
// - modulator order and dither fields
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "fpll_map.svh"
module fpll_ctrl #(
  parameter int RST_CYCLES = `FPLL_RST_CYCLES,
  parameter int CAL_CYCLES = `FPLL_CAL_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        power_down_n,
  input  wire logic        supply_ok,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             ref_div_tick,
  output logic             fb_div_tick,
  output logic [16:0]      fb_ratio,
  output logic             pd_up,
  output logic             pd_dn,
  output logic [3:0]       pump_current_select,
  output logic             filter_frac_bit,
  output logic [2:0]       filter_order_field,
  output logic             low_bw_bit,
  output logic [7:0]       out_mute,
  output logic             cal_active,
  output logic             loop_lock_en
);

  // ---------------------------------------------
  // state and wires
  // ---------------------------------------------
  fpll_pkg::fpll_ctrl_state_type s_q;
  fpll_pkg::fpll_ctrl_state_type s_d;
  fpll_pkg::fpll_cfg_type        cfg_def;

  logic               in_reset;
  logic               ref_tick;
  logic               fb_tick;
  logic               acc_en;
  logic [21:0]        acc1;
  logic [21:0]        acc2;
  logic               c1;
  logic               c2;
  logic               c3;
  logic [21:0]        dith;
  logic [21:0]        inc1;
  logic signed [4:0]  y;
  logic signed [18:0] n_s;
  logic [31:0]        rd_word;

  always_comb begin
    cfg_def.soft_rst   = `FPLL_DEF_SRST;
    cfg_def.prediv     = `FPLL_DEF_PREDIV;
    cfg_def.fb_int     = `FPLL_DEF_FBINT;
    cfg_def.num        = `FPLL_DEF_FBNUM;
    cfg_def.frac_bottom        = `FPLL_DEF_FBDEN;
    cfg_def.pump       = `FPLL_DEF_PUMP;
    cfg_def.filt_frac  = `FPLL_DEF_FILT_FRAC;
    cfg_def.filt_order = `FPLL_DEF_FILT_ORD;
    cfg_def.low_bw     = `FPLL_DEF_LOWBW;
    cfg_def.mod_order  = `FPLL_DEF_MOD_ORD;
    cfg_def.dither     = `FPLL_DEF_DITHER;
    cfg_def.mute_en    = `FPLL_DEF_MUTE_EN;
  end

  // ---------------------------------------------
  // dividers and modulator stages
  // ---------------------------------------------
  assign in_reset = !power_down_n || !s_q.cfg.soft_rst;
  assign acc_en   = fb_tick && (s_q.cfg.mod_order != 2'h0);

  fpll_div #(.W(5)) u_prediv (
    .clk    (ref_clk),
    .arst_n (arst_n),
    .clr    (in_reset),
    .ratio  (s_q.cfg.prediv),
    .tick_q (ref_tick)
  );

  fpll_div #(.W(17)) u_fbdiv (
    .clk    (ref_clk),
    .arst_n (arst_n),
    .clr    (in_reset),
    .ratio  (s_q.n),
    .tick_q (fb_tick)
  );

  fpll_acc #(.W(22)) u_acc1 (
    .clk     (ref_clk),
    .arst_n  (arst_n),
    .clr     (in_reset),
    .en      (acc_en),
    .inc     (inc1),
    .modulus (s_q.cfg.frac_bottom),
    .acc_q   (acc1),
    .carry_q (c1)
  );

  fpll_acc #(.W(22)) u_acc2 (
    .clk     (ref_clk),
    .arst_n  (arst_n),
    .clr     (in_reset),
    .en      (acc_en),
    .inc     (acc1),
    .modulus (s_q.cfg.frac_bottom),
    .acc_q   (acc2),
    .carry_q (c2)
  );

  fpll_acc #(.W(22)) u_acc3 (
    .clk     (ref_clk),
    .arst_n  (arst_n),
    .clr     (in_reset),
    .en      (acc_en),
    .inc     (acc2),
    .modulus (s_q.cfg.frac_bottom),
    .acc_q   (),
    .carry_q (c3)
  );

  // ---------------------------------------------
  // dither and modulator output
  // ---------------------------------------------
  always_comb begin
    case (s_q.cfg.dither)
      2'h1:    dith = {21'h000000, s_q.lfsr[0]};
      2'h2:    dith = {20'h00000, s_q.lfsr[1:0]};
      2'h3:    dith = {19'h00000, s_q.lfsr[2:0]};
      default: dith = 22'h000000;
    endcase
    inc1 = s_q.cfg.num + dith;
    case (s_q.cfg.mod_order)
      2'h1:    y = $signed({4'h0, c1});
      2'h2:    y = $signed({4'h0, c1}) + $signed({4'h0, c2}) - $signed({4'h0, s_q.c2p});
      2'h3:    y = $signed({4'h0, c1}) + $signed({4'h0, c2}) - $signed({4'h0, s_q.c2p})
                   + $signed({4'h0, c3}) - $signed({3'h0, s_q.c3p, 1'b0}) + $signed({4'h0, s_q.c3pp});
      default: y = 5'sh00;
    endcase
    n_s = $signed({3'h0, s_q.cfg.fb_int}) + 19'(y);
  end

  // ---------------------------------------------
  // register read mux
  // ---------------------------------------------
  always_comb begin
    rd_word = 32'h00000000;
    case (avs_address)
      `FPLL_OFF_CTRL:   rd_word[`FPLL_CTRL_SRST] = s_q.cfg.soft_rst;
      `FPLL_OFF_PREDIV: rd_word = {27'h0000000, s_q.cfg.prediv};
      `FPLL_OFF_FBINT:  rd_word = {16'h0000, s_q.cfg.fb_int};
      `FPLL_OFF_FBNUM:  rd_word = {10'h000, s_q.cfg.num};
      `FPLL_OFF_FBDEN:  rd_word = {10'h000, s_q.cfg.frac_bottom};
      `FPLL_OFF_PUMP:   rd_word = {28'h0000000, s_q.cfg.pump};
      `FPLL_OFF_FILTER: begin
        rd_word[`FPLL_FILT_FRAC]                     = s_q.cfg.filt_frac;
        rd_word[`FPLL_FILT_ORD_HI:`FPLL_FILT_ORD_LO] = s_q.cfg.filt_order;
        rd_word[`FPLL_FILT_LOWBW]                    = s_q.cfg.low_bw;
      end
      `FPLL_OFF_DSM: begin
        rd_word[`FPLL_DSM_ORD_HI:`FPLL_DSM_ORD_LO]   = s_q.cfg.mod_order;
        rd_word[`FPLL_DSM_DITH_HI:`FPLL_DSM_DITH_LO] = s_q.cfg.dither;
      end
      `FPLL_OFF_MUTE:   rd_word = {24'h000000, s_q.cfg.mute_en};
      `FPLL_OFF_STATUS: begin
        rd_word[`FPLL_STAT_ST_HI:`FPLL_STAT_ST_LO] = s_q.st;
        rd_word[`FPLL_STAT_CAL]                    = s_q.cal;
        rd_word[`FPLL_STAT_LOCK]                   = s_q.lock;
        rd_word[`FPLL_STAT_SUPPLY]                 = supply_ok;
      end
      default:          rd_word = 32'h00000000;
    endcase
  end

  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb begin
    s_d = s_q;

    // bus slave: one wait cycle, then answer
    s_d.waitreq = 1'b1;
    if ((avs_read || avs_write) && s_q.waitreq) begin
      s_d.waitreq = 1'b0;
      s_d.rdata   = rd_word;
    end
    if (avs_write && !s_q.waitreq) begin
      case (avs_address)
        `FPLL_OFF_CTRL:   s_d.cfg.soft_rst = avs_writedata[`FPLL_CTRL_SRST];
        `FPLL_OFF_PREDIV: s_d.cfg.prediv = avs_writedata[4:0];
        `FPLL_OFF_FBINT:  s_d.cfg.fb_int = avs_writedata[15:0];
        `FPLL_OFF_FBNUM:  s_d.cfg.num = avs_writedata[21:0];
        `FPLL_OFF_FBDEN:  s_d.cfg.frac_bottom = avs_writedata[21:0];
        `FPLL_OFF_PUMP:   s_d.cfg.pump = avs_writedata[3:0];
        `FPLL_OFF_FILTER: begin
          s_d.cfg.filt_frac  = avs_writedata[`FPLL_FILT_FRAC];
          s_d.cfg.filt_order = avs_writedata[`FPLL_FILT_ORD_HI:`FPLL_FILT_ORD_LO];
          s_d.cfg.low_bw     = avs_writedata[`FPLL_FILT_LOWBW];
        end
        `FPLL_OFF_DSM: begin
          s_d.cfg.mod_order = avs_writedata[`FPLL_DSM_ORD_HI:`FPLL_DSM_ORD_LO];
          s_d.cfg.dither    = avs_writedata[`FPLL_DSM_DITH_HI:`FPLL_DSM_DITH_LO];
        end
        `FPLL_OFF_MUTE:   s_d.cfg.mute_en = avs_writedata[7:0];
        default:          s_d.cfg = s_q.cfg;
      endcase
    end

    // pin held low: bank loads defaults, so release leaves them in place
    if (!power_down_n) begin
      s_d.cfg = cfg_def;
    end

    // modulator history and dither source, once per feedback cycle
    if (in_reset) begin
      s_d.c2p  = 1'b0;
      s_d.c3p  = 1'b0;
      s_d.c3pp = 1'b0;
      s_d.lfsr = `FPLL_LFSR_SEED;
    end else if (acc_en) begin
      s_d.c2p  = c2;
      s_d.c3p  = c3;
      s_d.c3pp = s_q.c3p;
      s_d.lfsr = s_q.lfsr[0] ? ((s_q.lfsr >> 1) ^ `FPLL_LFSR_TAPS) : (s_q.lfsr >> 1);
    end

    // next integer division value
    if (n_s < 19'sd1) begin
      s_d.n = 17'h00001;
    end else begin
      s_d.n = n_s[16:0];
    end

    // reset and calibration sequencer
    case (s_q.st)
      fpll_pkg::FPLL_ST_RESET: begin
        s_d.timer = 16'h0000;
        if (!in_reset) begin
          s_d.st = fpll_pkg::FPLL_ST_WAIT;
        end
      end
      fpll_pkg::FPLL_ST_WAIT: begin
        if (s_q.timer < 16'(RST_CYCLES)) begin
          s_d.timer = s_q.timer + 16'h0001;
        end else if (supply_ok) begin
          s_d.timer = 16'h0000;
          s_d.st    = fpll_pkg::FPLL_ST_CAL;
        end
      end
      fpll_pkg::FPLL_ST_CAL: begin
        s_d.timer = s_q.timer + 16'h0001;
        if (s_q.timer >= 16'(CAL_CYCLES - 1)) begin
          s_d.st = fpll_pkg::FPLL_ST_LOCK;
        end
      end
      fpll_pkg::FPLL_ST_LOCK: begin
        s_d.timer = 16'h0000;
      end
      default: begin
        s_d.st = fpll_pkg::FPLL_ST_RESET;
      end
    endcase
    if (in_reset) begin
      s_d.st = fpll_pkg::FPLL_ST_RESET;
    end

    s_d.cal  = (s_d.st == fpll_pkg::FPLL_ST_CAL);
    s_d.lock = (s_d.st == fpll_pkg::FPLL_ST_LOCK);
    s_d.mute = s_d.lock ? 8'h00 : s_d.cfg.mute_en;

    // phase/frequency detector, active while locking
    if (s_d.lock) begin
      s_d.up = s_q.up || ref_tick;
      s_d.dn = s_q.dn || fb_tick;
      if (s_d.up && s_d.dn) begin
        s_d.up = 1'b0;
        s_d.dn = 1'b0;
      end
    end else begin
      s_d.up = 1'b0;
      s_d.dn = 1'b0;
    end
  end

  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q                <= '0;
      s_q.cfg.soft_rst   <= `FPLL_DEF_SRST;
      s_q.cfg.prediv     <= `FPLL_DEF_PREDIV;
      s_q.cfg.fb_int     <= `FPLL_DEF_FBINT;
      s_q.cfg.frac_bottom        <= `FPLL_DEF_FBDEN;
      s_q.cfg.pump       <= `FPLL_DEF_PUMP;
      s_q.cfg.filt_order <= `FPLL_DEF_FILT_ORD;
      s_q.cfg.low_bw     <= `FPLL_DEF_LOWBW;
      s_q.cfg.mute_en    <= `FPLL_DEF_MUTE_EN;
      s_q.mute           <= `FPLL_DEF_MUTE_EN;
      s_q.lfsr           <= `FPLL_LFSR_SEED;
      s_q.waitreq        <= 1'b1;
      s_q.n              <= 17'h00001;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign avs_readdata        = s_q.rdata;
  assign avs_waitrequest     = s_q.waitreq;
  assign ref_div_tick        = ref_tick;
  assign fb_div_tick         = fb_tick;
  assign fb_ratio            = s_q.n;
  assign pd_up               = s_q.up;
  assign pd_dn               = s_q.dn;
  assign pump_current_select = s_q.cfg.pump;
  assign filter_frac_bit     = s_q.cfg.filt_frac;
  assign filter_order_field  = s_q.cfg.filt_order;
  assign low_bw_bit          = s_q.cfg.low_bw;
  assign out_mute            = s_q.mute;
  assign cal_active          = s_q.cal;
  assign loop_lock_en        = s_q.lock;

endmodule

// File: design/fpll_map.svh
`ifndef FPLL_MAP_SVH
`define FPLL_MAP_SVH

// ---------------------------------------------
// register byte offsets
// ---------------------------------------------
`define FPLL_OFF_CTRL    8'h00
`define FPLL_OFF_PREDIV  8'h04
`define FPLL_OFF_FBINT   8'h08
`define FPLL_OFF_FBNUM   8'h0C
`define FPLL_OFF_FBDEN   8'h10
`define FPLL_OFF_PUMP    8'h14
`define FPLL_OFF_FILTER  8'h18
`define FPLL_OFF_DSM     8'h1C
`define FPLL_OFF_MUTE    8'h20
`define FPLL_OFF_STATUS  8'h24

// ---------------------------------------------
// field positions
// ---------------------------------------------
`define FPLL_CTRL_SRST      0
`define FPLL_FILT_FRAC      0
`define FPLL_FILT_ORD_LO    4
`define FPLL_FILT_ORD_HI    6
`define FPLL_FILT_LOWBW     8
`define FPLL_DSM_ORD_LO     0
`define FPLL_DSM_ORD_HI     1
`define FPLL_DSM_DITH_LO    2
`define FPLL_DSM_DITH_HI    3
`define FPLL_STAT_ST_LO     0
`define FPLL_STAT_ST_HI     1
`define FPLL_STAT_CAL       2
`define FPLL_STAT_LOCK      3
`define FPLL_STAT_SUPPLY    4

// ---------------------------------------------
// pin-mode defaults
// ---------------------------------------------
`define FPLL_DEF_SRST       1'h1
`define FPLL_DEF_PREDIV     5'h01
`define FPLL_DEF_FBINT      16'h0032
`define FPLL_DEF_FBNUM      22'h000000
`define FPLL_DEF_FBDEN      22'h000001
`define FPLL_DEF_PUMP       4'h1
`define FPLL_DEF_FILT_FRAC  1'h0
`define FPLL_DEF_FILT_ORD   3'h3
`define FPLL_DEF_LOWBW      1'h1
`define FPLL_DEF_MOD_ORD    2'h0
`define FPLL_DEF_DITHER     2'h0
`define FPLL_DEF_MUTE_EN    8'hFF
`define FPLL_LFSR_SEED      16'hACE1
`define FPLL_LFSR_TAPS      16'hB400

// ---------------------------------------------
// timing
// ---------------------------------------------
`define FPLL_CLK_PERIOD_NS  10
`define FPLL_RST_TIME_NS    1000
`define FPLL_RST_CYCLES     ((`FPLL_RST_TIME_NS + `FPLL_CLK_PERIOD_NS - 1) / `FPLL_CLK_PERIOD_NS)
`define FPLL_CAL_CYCLES     512

`endif

// File: design/fpll_pkg.sv
package fpll_pkg;

  typedef enum logic [1:0] {
    FPLL_ST_RESET,
    FPLL_ST_WAIT,
    FPLL_ST_CAL,
    FPLL_ST_LOCK
  } fpll_state_type;

  typedef struct packed {
    logic        soft_rst;
    logic [4:0]  prediv;
    logic [15:0] fb_int;
    logic [21:0] num;
    logic [21:0] frac_bottom;
    logic [3:0]  pump;
    logic        filt_frac;
    logic [2:0]  filt_order;
    logic        low_bw;
    logic [1:0]  mod_order;
    logic [1:0]  dither;
    logic [7:0]  mute_en;
  } fpll_cfg_type;

  typedef struct packed {
    fpll_cfg_type   cfg;
    fpll_state_type st;
    logic [15:0]    timer;
    logic           c2p;
    logic           c3p;
    logic           c3pp;
    logic [15:0]    lfsr;
    logic           up;
    logic           dn;
    logic [7:0]     mute;
    logic           cal;
    logic           lock;
    logic           waitreq;
    logic [31:0]    rdata;
    logic [16:0]    n;
  } fpll_ctrl_state_type;

endpackage

// File: design/fpll_div.sv
`timescale 1ns/1ps
module fpll_div #(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         clr,
  input  wire logic [W-1:0] ratio,
  output logic              tick_q
);

  // ---------------------------------------------
  // free-running counter, one tick per ratio clocks
  // ---------------------------------------------
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } fpll_div_state_type;

  fpll_div_state_type s_q;
  fpll_div_state_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (clr) begin
      s_d.cnt = '0;
    end else if (ratio == '0 || s_q.cnt >= ratio - W'(1)) begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + W'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_q = s_q.tick;

endmodule

// File: design/fpll_acc.sv
`timescale 1ns/1ps
module fpll_acc #(
  parameter int W = 22
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         clr,
  input  wire logic         en,
  input  wire logic [W-1:0] inc,
  input  wire logic [W-1:0] modulus,
  output logic [W-1:0]      acc_q,
  output logic              carry_q
);

  // ---------------------------------------------
  // modulo accumulator stage
  // ---------------------------------------------
  typedef struct packed {
    logic [W-1:0] acc;
    logic         carry;
  } fpll_acc_state_type;

  fpll_acc_state_type s_q;
  fpll_acc_state_type s_d;
  logic [W:0]         sum;

  always_comb begin
    s_d = s_q;
    sum = {1'b0, s_q.acc} + {1'b0, inc};
    if (clr) begin
      s_d = '0;
    end else if (en) begin
      if (sum >= {1'b0, modulus}) begin
        s_d.acc   = W'(sum - {1'b0, modulus});
        s_d.carry = 1'b1;
      end else begin
        s_d.acc   = sum[W-1:0];
        s_d.carry = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign acc_q   = s_q.acc;
  assign carry_q = s_q.carry;

endmodule

// File: bench/fpll_chk.sv
`timescale 1ns/1ps
module fpll_chk #(
  parameter int RST_CYCLES = 100,
  parameter int CAL_CYCLES = 512
) (
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic       power_down_n,
  input wire logic       supply_ok,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic       ref_div_tick,
  input wire logic       fb_div_tick,
  input wire logic       pd_up,
  input wire logic       pd_dn,
  input wire logic [7:0] out_mute,
  input wire logic       cal_active,
  input wire logic       loop_lock_en
);
  // ----------------------------
  // cycle counters
  // ----------------------------
  logic [15:0] idle_q;
  logic [15:0] cal_q;
  logic [5:0]  gap_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_q <= 16'h0000;
      cal_q  <= 16'h0000;
      gap_q  <= 6'h00;
    end else begin
      idle_q <= (!power_down_n || cal_active || loop_lock_en) ? 16'h0000 : idle_q + 16'h0001;
      cal_q  <= cal_active ? cal_q + 16'h0001 : 16'h0000;
      gap_q  <= ref_div_tick ? 6'h00 : ((gap_q == 6'h3F) ? gap_q : gap_q + 6'h01);
    end
  end

  // ----------------------------
  // properties
  // ----------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  sequence s_pdn2;
    !power_down_n ##1 !power_down_n;
  endsequence

  AST_BUS_ANSWER: assert property (s_req |=> s_ans)
    else $error("bus answer not one cycle after request");
  AST_BUS_IDLE: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer without request");
  AST_PDN_RESET: assert property (!power_down_n |=> !cal_active && !loop_lock_en)
    else $error("pin low did not reset sequencer");
  AST_PDN_QUIET: assert property (!power_down_n |=> !ref_div_tick && !fb_div_tick && !pd_up && !pd_dn)
    else $error("dividers or detector active in reset");
  AST_PDN_DEFAULT: assert property (s_pdn2 |=> out_mute == 8'hFF)
    else $error("mute defaults not reloaded");
  AST_CAL_ENTRY: assert property ($rose(cal_active) |-> $past(supply_ok) && int'(idle_q) >= RST_CYCLES)
    else $error("calibration started early");
  AST_CAL_LENGTH: assert property ($rose(loop_lock_en) |-> int'(cal_q) == CAL_CYCLES)
    else $error("calibration length wrong");
  AST_LOCK_UNMUTE: assert property (loop_lock_en && $past(loop_lock_en) |-> out_mute == 8'h00)
    else $error("outputs muted in lock");
  AST_PFD_IDLE: assert property (!loop_lock_en && !$past(loop_lock_en) |-> !pd_up && !pd_dn)
    else $error("detector active outside lock");
  AST_PFD_UP: assert property (loop_lock_en && ref_div_tick && !fb_div_tick && !pd_dn |=> pd_up || !loop_lock_en)
    else $error("reference tick did not raise up");
  AST_REF_GAP: assert property (loop_lock_en |-> gap_q < 6'h20)
    else $error("pre-divider stalled");
endmodule

bind fpll_ctrl fpll_chk #(.RST_CYCLES(RST_CYCLES), .CAL_CYCLES(CAL_CYCLES)) u_chk (
  .ref_clk(ref_clk), .arst_n(arst_n), .power_down_n(power_down_n), .supply_ok(supply_ok),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .ref_div_tick(ref_div_tick), .fb_div_tick(fb_div_tick), .pd_up(pd_up), .pd_dn(pd_dn),
  .out_mute(out_mute), .cal_active(cal_active), .loop_lock_en(loop_lock_en)
);

// File: bench/fpll_host.sv
`timescale 1ns/1ps
module fpll_host (
  input  wire logic  clk,
  input  wire logic  avs_waitrequest,
  output logic       power_down_n,
  output logic [7:0] avs_address,
  output logic       avs_read,
  output logic       avs_write,
  output logic [31:0] avs_writedata
);
  // ----------------------------
  // pin and register bus master
  // ----------------------------
  logic [31:0] exp_q[$];

  initial begin
    power_down_n  = 1'b1;
    avs_address   = 8'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h00000000;
  end

  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_read      <= !w;
    avs_write     <= w;
    avs_address   <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask

  // expected word is noted before the request goes out
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 32'h00000000);
  endtask

  task automatic pin(input logic v);
    @(posedge clk);
    power_down_n <= v;
  endtask
endmodule

// File: bench/fractional_pll_control_tb.sv
`timescale 1ns/1ps
module fractional_pll_control_tb;
  logic        ref_clk, arst_n, supply_ok, power_down_n, avs_read, avs_write, avs_waitrequest;
  logic        ref_div_tick, fb_div_tick, pd_up, pd_dn, filter_frac_bit, low_bw_bit, cal_active, loop_lock_en;
  logic [7:0]  avs_address, out_mute;
  logic [31:0] avs_writedata, avs_readdata;
  logic [16:0] fb_ratio;
  logic [3:0]  pump_current_select;
  logic [2:0]  filter_order_field;
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [7:0]  da [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h28};
  logic [31:0] dv [10] = '{32'h1, 32'h1, 32'h32, 32'h0, 32'h1, 32'h1, 32'h130, 32'h0, 32'hFF, 32'h0};

  fpll_host host (.clk(ref_clk), .avs_waitrequest(avs_waitrequest), .power_down_n(power_down_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata));
  fpll_ctrl #(.RST_CYCLES(4), .CAL_CYCLES(8)) dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .power_down_n(power_down_n), .supply_ok(supply_ok),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ref_div_tick(ref_div_tick),
    .fb_div_tick(fb_div_tick), .fb_ratio(fb_ratio), .pd_up(pd_up), .pd_dn(pd_dn),
    .pump_current_select(pump_current_select), .filter_frac_bit(filter_frac_bit),
    .filter_order_field(filter_order_field), .low_bw_bit(low_bw_bit), .out_mute(out_mute),
    .cal_active(cal_active), .loop_lock_en(loop_lock_en));

  // ----------------------------
  // clock, checks, verdict
  // ----------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_v(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t output %h expected %h", $time, got, exp);
    end
  endtask

  always @(posedge ref_clk) begin
    if (avs_waitrequest === 1'b0 && avs_read === 1'b1) begin
      cmp_rd(avs_readdata, host.exp_q.pop_front());
    end
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      give_verdict();
    end
  end

  // cycles covered by n tick periods, after settling over 8 fresh ticks
  task automatic span(input logic fb, input int n, output int t);
    t = 0;
    repeat (8) do @(negedge ref_clk); while ((fb ? fb_div_tick : ref_div_tick) !== 1'b1);
    repeat (n) do begin
      @(negedge ref_clk);
      t++;
    end while ((fb ? fb_div_tick : ref_div_tick) !== 1'b1);
  endtask

  task automatic run_cal(input logic [7:0] m);
    while (cal_active !== 1'b1) @(negedge ref_clk);
    cmp_v(out_mute, m);
    while (loop_lock_en !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    cmp_v(out_mute, 8'h00);
    host.rd(8'h24, 32'h1B);
  endtask

  // ----------------------------
  // scenarios
  // ----------------------------
  initial begin
    int r, p, t, d, k, lb;
    arst_n    = 1'b0;
    supply_ok = 1'b0;
    void'($urandom(94));
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    for (k = 0; k < 10; k++) host.rd(da[k], dv[k]);
    @(negedge ref_clk);
    cmp_v({cal_active, out_mute}, 9'h0FF);
    @(posedge ref_clk);
    supply_ok <= 1'b1;
    run_cal(8'hFF);
    p = 1 + $urandom % 31;
    host.wr(8'h04, p);
    span(1'b0, 1, t);
    cmp_v(t, p);
    for (k = 0; k < 4; k++) begin
      r  = 8 + $urandom % 16;
      lb = $urandom % 2;
      p  = 1 + $urandom % 15;
      host.wr(8'h08, r);
      host.wr(8'h0C, k ? 3 : 0);
      host.wr(8'h10, 8);
      host.wr(8'h18, (k ? 32'h71 : 32'h30) | (lb << 8));
      host.wr(8'h14, p);
      host.wr(8'h1C, k);
      host.rd(8'h1C, k);
      cmp_v({low_bw_bit, filter_order_field, filter_frac_bit}, {lb[0], (k ? 3'h7 : 3'h3), k != 0});
      cmp_v(pump_current_select, p);
      span(1'b1, 64, t);
      d = t - 64 * r - (k ? 24 : 0);
      cmp_v(k ? (d > -9 && d < 9) : (d == 0), 1'b1);
      cmp_v(k ? (fb_ratio + 3 >= r && fb_ratio <= r + 4) : (fb_ratio == r), 1'b1);
    end
    for (k = 0; k < 4; k++) begin
      host.wr(8'h1C, k << 2);
      host.rd(8'h1C, k << 2);
    end
    host.wr(8'h20, 8'h0F);
    host.wr(8'h00, 0);
    repeat (2) @(negedge ref_clk);
    cmp_v({cal_active, loop_lock_en, out_mute}, 10'h00F);
    host.wr(8'h00, 1);
    run_cal(8'h0F);
    host.rd(8'h20, 8'h0F);
    host.rd(8'h08, r);
    host.pin(1'b0);
    repeat (3) @(negedge ref_clk);
    cmp_v({cal_active, loop_lock_en, out_mute}, 10'h0FF);
    host.pin(1'b1);
    run_cal(8'hFF);
    host.rd(8'h20, 8'hFF);
    host.rd(8'h08, 8'h32);
    host.wr(8'h24, 0);
    host.rd(8'h24, 32'h1B);
    host.rd(8'h00, 1);
    give_verdict();
  end
endmodule
